// ### design/cps_regs.vh
// Register offsets, field positions, reset values and timing counts of the power stage block.
`ifndef CPS_REGS_VH
`define CPS_REGS_VH

// ============================================================
// Register byte offsets
`define CPS_CTRL_OFS     8'h00
`define CPS_CMD_OFS      8'h04
`define CPS_CFG7_OFS     8'h08
`define CPS_CFG10_OFS    8'h0C
`define CPS_STEP_HI_OFS  8'h10
`define CPS_STEP_LO_OFS  8'h14
`define CPS_DIAG_OFS     8'h18
`define CPS_STAT_OFS     8'h1C

// ============================================================
// Control word fields
`define CPS_CTRL_EN      0
`define CPS_CTRL_DIR     1
`define CPS_CTRL_STEP    2
`define CPS_CTRL_SRST    3

// ============================================================
// Configuration word seven fields
`define CPS_CFG7_ARR_LSB 0
`define CPS_CFG7_HOLD_A  2
`define CPS_CFG7_HOLD_C  3
`define CPS_CFG7_PAR_L1  4
`define CPS_CFG7_PAR_L2  5
`define CPS_ARR_HBRIDGE  2'h0
`define CPS_ARR_INDEP    2'h1

// ============================================================
// Configuration word ten fields
`define CPS_CFG10_PAR_H1 0
`define CPS_CFG10_PAR_H2 1

// ============================================================
// Diagnosis word fields and fault codes
`define CPS_DIAG_ANY     16
`define CPS_DIAG_THERM   17
`define CPS_FLT_NONE     2'h0
`define CPS_FLT_SCB      2'h1
`define CPS_FLT_SCG      2'h2
`define CPS_FLT_OL       2'h3

// ============================================================
// Step counter
`define CPS_STEP_INIT    10'h200
`define CPS_STEP_MAX     10'h3FF
`define CPS_STEP_MIN     10'h000

// ============================================================
// Timing
`define CPS_CLK_MHZ      250
`define CPS_OC_FILT_US   10
`define CPS_OC_FILT_CYC  (`CPS_OC_FILT_US * `CPS_CLK_MHZ)
`define CPS_HOLD_US      500
`define CPS_HOLD_CYC     (`CPS_HOLD_US * `CPS_CLK_MHZ)

`endif

// ### design/cps_ctrl.v
// Control logic of the eight configurable power stages: bridges, stepping, hold and diagnosis.
//
// The plain strobed port and the register offsets were left to the implementer.
`include "cps_regs.vh"

// Notes on behaviour
// - Arrangement bits pick two H-bridges or eight stages; H-bridge after reset.
// - Independent mode lets low-side pairs run in parallel, no coherency check.
// - Enabled hold keeps b1_hs_a, b2_hs_c on for hold time after reset fall.
// - Each high-side hold has its own enable bit in config word seven.
// - Any hold enable set forces the independent arrangement.
// - With enable high, step bit 0 to 1 advances one position; 0 holds.
// - In H-bridge mode, enable low turns every bridge switch off.
// - Direction 1 walks the four positions forward, direction 0 backward.
// - Power-on position is b1_hs_a, b1_ls_b and b2_hs_d, b2_ls_c.
// - H-bridge mode never turns on both switches of one half-bridge.
// - Direction and step written together step once in the old direction.
// - Enable and step written together act only on the enable.
// - Ten-bit step counter, read as upper and lower five-bit halves.
// - Step counter starts at 512.
// - Counter counts up on direction 1 steps, down on direction 0 steps.
// - Counter saturates at its limits until a reverse step.
// - Both counter halves carry two check bits naming the step.
// - Power-on and software reset return the counter to 512.
// - Parallel pairs are chosen by config words seven and ten.
// - Short to battery detected on; short to ground, open load off; thermal warning.
// - Fault codes sit in a diagnosis register cleared when it is read.
// - One summary bit flags a fault on any of the eight outputs.
// - Filtered over-current turns the bridge off until a new on command.
// - Off-state fault may be replaced by on fault and never blocks switching on.
module cps_ctrl #(
   parameter HOLD_CYC = `CPS_HOLD_CYC
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_b,
   // Register port
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // Microcontroller reset pin and analog fault comparators
   input  wire        mcu_rst_b,
   input  wire [7:0]  short_to_battery,
   input  wire [7:0]  short_to_ground,
   input  wire [7:0]  open_load,
   input  wire        thermal_warning_two,
   // Power stage drives
   output wire        b1_hs_a,
   output wire        b1_ls_a,
   output wire        b1_hs_b,
   output wire        b1_ls_b,
   output wire        b2_hs_c,
   output wire        b2_hs_d,
   output wire        b2_ls_c,
   output wire        b2_ls_d,
   // Summary fault
   output wire        any_output_fault_flag
);

   // ============================================================
   // Declarations
   reg  [25:0] sync1;
   reg  [25:0] sync2;
   reg         mcu_q;
   reg         en;
   reg         dir;
   reg         step_bit;
   reg  [1:0]  pos;
   reg  [9:0]  step_cnt;
   reg  [1:0]  step_tag;
   reg  [7:0]  cmd;
   reg  [5:0]  cfg7;
   reg  [1:0]  cfg10;
   reg  [7:0]  trip;
   reg  [7:0]  stage_q;
   reg  [15:0] dcode;
   reg         therm;
   reg         hold_run;
   reg  [23:0] hold_cnt;
   reg  [11:0] oc_cnt [0:7];
   reg  [15:0] next_dcode;
   reg  [7:0]  hb;
   reg  [7:0]  ind;
   reg  [7:0]  drv;
   reg  [7:0]  on_flt;
   reg  [31:0] rd_mux;
   integer     i;
   integer     j;
   integer     k;

   wire [7:0]  scb_s   = sync2[7:0];
   wire [7:0]  scg_s   = sync2[15:8];
   wire [7:0]  ol_s    = sync2[23:16];
   wire        therm_s = sync2[24];
   wire        mcu_s   = sync2[25];

   // ============================================================
   // Register decode
   wire wr_ctrl = reg_wr && (reg_addr == `CPS_CTRL_OFS);
   wire wr_cmd  = reg_wr && (reg_addr == `CPS_CMD_OFS);
   wire wr_cfg7 = reg_wr && (reg_addr == `CPS_CFG7_OFS);
   wire wr_cf10 = reg_wr && (reg_addr == `CPS_CFG10_OFS);
   wire rd_diag = reg_rd && (reg_addr == `CPS_DIAG_OFS);

   wire en_new   = reg_wdata[`CPS_CTRL_EN];
   wire dir_new  = reg_wdata[`CPS_CTRL_DIR];
   wire step_new = reg_wdata[`CPS_CTRL_STEP];
   wire soft_rst = wr_ctrl && reg_wdata[`CPS_CTRL_SRST];

   // Arrangement: any hold enable overrides the select bits.
   wire hold_a  = cfg7[`CPS_CFG7_HOLD_A];
   wire hold_c  = cfg7[`CPS_CFG7_HOLD_C];
   wire hbridge = (cfg7[1:0] != `CPS_ARR_INDEP) && !(hold_a || hold_c);

   // Enable change in the same write masks the step bit.
   wire en_chg  = wr_ctrl && (en_new != en);
   wire step_go = wr_ctrl && hbridge && en && !en_chg
                  && !step_bit && step_new;
   wire br_on   = wr_ctrl && en_new && !en;

   // Counter end points, cut to the width of the counters that meet them.
   localparam integer HOLD_END  = HOLD_CYC - 1;
   localparam [23:0]  HOLD_LAST = HOLD_END[23:0];
   localparam integer OC_FILT   = `CPS_OC_FILT_CYC;
   localparam [11:0]  OC_LAST   = OC_FILT[11:0];

   // Hold timer end without host takeover.
   wire hold_end = hold_run && (hold_cnt == HOLD_LAST);

   // ============================================================
   // Two-stage synchronisers on every pin input
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1 <= 26'h2000000;
         sync2 <= 26'h2000000;
         mcu_q <= 1'b1;
      end else begin
         sync1 <= {mcu_rst_b, thermal_warning_two, open_load, short_to_ground,
                   short_to_battery};
         sync2 <= sync1;
         mcu_q <= mcu_s;
      end
   end

   // ============================================================
   // Bridge drive from position; bridge two phase is pos[1] xor pos[0].
   always @* begin
      hb[0] = en && !(|trip[3:0]) && !pos[1];
      hb[3] = hb[0];
      hb[2] = en && !(|trip[3:0]) && pos[1];
      hb[1] = hb[2];
      hb[4] = en && !(|trip[7:4]) && (pos[1] ^ pos[0]);
      hb[7] = hb[4];
      hb[5] = en && !(|trip[7:4]) && !(pos[1] ^ pos[0]);
      hb[6] = hb[5];
   end

   // Independent drive with parallel pairs following each other.
   always @* begin
      ind    = cmd;
      ind[1] = cmd[1] | (cfg7[`CPS_CFG7_PAR_L1] & cmd[3]);
      ind[3] = cmd[3] | (cfg7[`CPS_CFG7_PAR_L1] & cmd[1]);
      ind[6] = cmd[6] | (cfg7[`CPS_CFG7_PAR_L2] & cmd[7]);
      ind[7] = cmd[7] | (cfg7[`CPS_CFG7_PAR_L2] & cmd[6]);
      ind[0] = cmd[0] | (cfg10[`CPS_CFG10_PAR_H1] & cmd[2]);
      ind[2] = cmd[2] | (cfg10[`CPS_CFG10_PAR_H1] & cmd[0]);
      ind[4] = cmd[4] | (cfg10[`CPS_CFG10_PAR_H2] & cmd[5]);
      ind[5] = cmd[5] | (cfg10[`CPS_CFG10_PAR_H2] & cmd[4]);
      ind    = ind & ~trip;
   end

   // Final selection; in bridge mode a low side yields to its own high side.
   always @* begin
      if (hbridge) begin
         drv    = hb;
         drv[1] = hb[1] & ~hb[0];
         drv[3] = hb[3] & ~hb[2];
         drv[6] = hb[6] & ~hb[4];
         drv[7] = hb[7] & ~hb[5];
      end else begin
         drv = ind;
      end
   end

   // ============================================================
   // Stepping, position and step counter
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         en       <= 1'b0;
         dir      <= 1'b0;
         step_bit <= 1'b0;
         pos      <= 2'h0;
         step_cnt <= `CPS_STEP_INIT;
         step_tag <= 2'h0;
      end else begin
         if (wr_ctrl) begin
            en  <= en_new;
            dir <= dir_new;
            if (!en_chg)
               step_bit <= step_new;
         end
         if (step_go) begin
            // The register still holds the old direction here.
            pos      <= dir ? pos + 2'h1 : pos - 2'h1;
            step_tag <= step_tag + 2'h1;
         end
         if (soft_rst) begin
            step_cnt <= `CPS_STEP_INIT;
            step_tag <= 2'h0;
         end else if (step_go) begin
            if (dir && step_cnt != `CPS_STEP_MAX)
               step_cnt <= step_cnt + 10'h001;
            else if (!dir && step_cnt != `CPS_STEP_MIN)
               step_cnt <= step_cnt - 10'h001;
         end
      end
   end

   // ============================================================
   // Configuration, stage commands and low-battery hold
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg7     <= {4'h0, `CPS_ARR_HBRIDGE};
         cfg10    <= 2'h0;
         cmd      <= 8'h00;
         hold_run <= 1'b0;
         hold_cnt <= 24'h000000;
      end else begin
         if (wr_cfg7)
            cfg7 <= reg_wdata[5:0];
         if (wr_cf10)
            cfg10 <= reg_wdata[1:0];
         if (wr_cmd)
            cmd <= reg_wdata[7:0];
         else if (hold_end) begin
            if (hold_a)
               cmd[0] <= 1'b0;
            if (hold_c)
               cmd[4] <= 1'b0;
         end
         // Timer starts at the falling edge of the controller reset.
         if (wr_cmd || hold_end) begin
            hold_run <= 1'b0;
            hold_cnt <= 24'h000000;
         end else if (mcu_q && !mcu_s && (hold_a || hold_c)) begin
            hold_run <= 1'b1;
            hold_cnt <= 24'h000000;
         end else if (hold_run) begin
            hold_cnt <= hold_cnt + 24'h000001;
         end
      end
   end

   // ============================================================
   // Over-current filter on the short to battery comparators
   always @* begin
      for (i = 0; i < 8; i = i + 1)
         on_flt[i] = (oc_cnt[i] == OC_LAST);
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (j = 0; j < 8; j = j + 1)
            oc_cnt[j] <= 12'h000;
      end else begin
         for (j = 0; j < 8; j = j + 1) begin
            if (!(scb_s[j] && stage_q[j]))
               oc_cnt[j] <= 12'h000;
            else if (!on_flt[j])
               oc_cnt[j] <= oc_cnt[j] + 12'h001;
         end
      end
   end

   // ============================================================
   // Trip latches and registered stage drives
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         trip    <= 8'h00;
         stage_q <= 8'h00;
      end else begin
         stage_q <= drv;
         if (hbridge) begin
            // A new on command re-arms the bridge; a fresh fault still wins.
            if (|on_flt[3:0])
               trip[3:0] <= 4'hF;
            else if (step_go || br_on)
               trip[3:0] <= 4'h0;
            if (|on_flt[7:4])
               trip[7:4] <= 4'hF;
            else if (step_go || br_on)
               trip[7:4] <= 4'h0;
         end else if (wr_cmd) begin
            trip <= on_flt;
         end else begin
            trip <= trip | on_flt;
         end
      end
   end

   // ============================================================
   // Fault code update; the read clear loses to a new fault.
   always @* begin
      next_dcode = rd_diag ? 16'h0000 : dcode;
      for (k = 0; k < 8; k = k + 1) begin
         if (on_flt[k])
            next_dcode[2*k +: 2] = `CPS_FLT_SCB;
         else if (!stage_q[k] && next_dcode[2*k +: 2] == `CPS_FLT_NONE) begin
            if (scg_s[k])
               next_dcode[2*k +: 2] = `CPS_FLT_SCG;
            else if (ol_s[k])
               next_dcode[2*k +: 2] = `CPS_FLT_OL;
         end
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dcode <= 16'h0000;
         therm <= 1'b0;
      end else begin
         dcode <= next_dcode;
         therm <= therm_s | (therm & !rd_diag);
      end
   end

   // ============================================================
   // Read multiplexer and read data register
   always @* begin
      case (reg_addr)
         `CPS_CTRL_OFS:    rd_mux = {29'h0, step_bit, dir, en};
         `CPS_CMD_OFS:     rd_mux = {24'h0, cmd};
         `CPS_CFG7_OFS:    rd_mux = {26'h0, cfg7};
         `CPS_CFG10_OFS:   rd_mux = {30'h0, cfg10};
         `CPS_STEP_HI_OFS: rd_mux = {25'h0, step_tag, step_cnt[9:5]};
         `CPS_STEP_LO_OFS: rd_mux = {25'h0, step_tag, step_cnt[4:0]};
         `CPS_DIAG_OFS:    rd_mux = {14'h0, therm, any_output_fault_flag, dcode};
         `CPS_STAT_OFS:    rd_mux = {20'h0, |trip, hold_run, pos, stage_q};
         default:          rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         reg_rdata <= 32'h00000000;
      else if (reg_rd)
         reg_rdata <= rd_mux;
      else
         reg_rdata <= 32'h00000000;
   end

   // ============================================================
   // Outputs
   assign b1_hs_a = stage_q[0];
   assign b1_ls_a = stage_q[1];
   assign b1_hs_b = stage_q[2];
   assign b1_ls_b = stage_q[3];
   assign b2_hs_c = stage_q[4];
   assign b2_hs_d = stage_q[5];
   assign b2_ls_c = stage_q[6];
   assign b2_ls_d = stage_q[7];
   assign any_output_fault_flag = (|dcode) | therm;

endmodule // cps_ctrl

// ### bench/cps_ctrl_sva.sv
// Concurrent checks on the port behaviour of the power stage control block.
`include "cps_regs.vh"

// ============================================================
// Checker
module cps_ctrl_sva #(
   parameter HOLD_CYC = `CPS_HOLD_CYC
) (
   // Clock and reset
   input wire        clk,
   input wire        rst_b,
   // Register port
   input wire [7:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [31:0] reg_rdata,
   // Controller reset pin and fault comparators
   input wire        mcu_rst_b,
   input wire [7:0]  short_to_battery,
   input wire [7:0]  short_to_ground,
   input wire [7:0]  open_load,
   input wire        thermal_warning_two,
   // Stage drives and summary fault
   input wire        b1_hs_a,
   input wire        b1_ls_a,
   input wire        b1_hs_b,
   input wire        b1_ls_b,
   input wire        b2_hs_c,
   input wire        b2_hs_d,
   input wire        b2_ls_c,
   input wire        b2_ls_d,
   input wire        any_output_fault_flag
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Drives packed in fault-vector order, and the shadow of the control state.
   wire [7:0]  drv = {b2_ls_d, b2_ls_c, b2_hs_d, b2_hs_c, b1_ls_b, b1_hs_b, b1_ls_a, b1_hs_a};
   wire        wr_ctl = reg_wr && reg_addr == `CPS_CTRL_OFS;
   logic       en_q, dir_q, stp_q, hb, moved, oc;
   logic [9:0] cnt, cnt_d;
   wire        acc = wr_ctl && hb && en_q && reg_wdata[0] && reg_wdata[2] && !stp_q;

   // Shadow registers; an enable change makes the step bit of that write ignored.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         en_q  <= 1'h0;
         dir_q <= 1'h0;
         stp_q <= 1'h0;
         hb    <= 1'h1;
         moved <= 1'h0;
         oc    <= 1'h0;
         cnt   <= `CPS_STEP_INIT;
         cnt_d <= `CPS_STEP_INIT;
      end else begin
         cnt_d <= cnt;
         moved <= moved | acc;
         oc    <= oc | (hb && |short_to_battery);
         if (wr_ctl) begin
            en_q  <= reg_wdata[0];
            dir_q <= reg_wdata[1];
            stp_q <= (reg_wdata[0] == en_q) ? reg_wdata[2] : stp_q;
         end
         if (reg_wr && reg_addr == `CPS_CFG7_OFS)
            hb <= reg_wdata[3:2] == 2'h0 && reg_wdata[1:0] != `CPS_ARR_INDEP;
         if (wr_ctl && reg_wdata[3])
            cnt <= `CPS_STEP_INIT;
         else if (acc && dir_q && cnt != `CPS_STEP_MAX)
            cnt <= cnt + 10'h001;
         else if (acc && !dir_q && cnt != `CPS_STEP_MIN)
            cnt <= cnt - 10'h001;
      end
   end

   sequence rd_at(logic [7:0] a);
      reg_rd && reg_addr == a;
   endsequence
   sequence step_taken;
      acc ##1 1'h1;
   endsequence

   chk_no_shoot_thru:
   assert property (hb && $past(hb) |-> !(b1_hs_a && b1_ls_a) && !(b1_hs_b && b1_ls_b)
      && !(b2_hs_c && b2_ls_c) && !(b2_hs_d && b2_ls_d)) else $error("Half-bridge shorted.");
   chk_disable_off:
   assert property (hb && $past(hb) && !$past(en_q) |-> drv == 8'h00)
      else $error("Bridge on while disabled.");
   chk_first_position:
   assert property (hb && $past(hb) && $past(en_q) && !$past(moved) && !oc |-> drv == 8'h69)
      else $error("Wrong power-on position.");
   chk_step_moves:
   assert property (step_taken |=> drv != $past(drv)) else $error("Step did not move.");
   chk_step_low_holds:
   assert property (wr_ctl && hb && en_q && reg_wdata[0] && !reg_wdata[2] && !oc ##1 1'h1
      |=> $stable(drv)) else $error("Step bit low moved the bridge.");
   chk_count_lower:
   assert property (rd_at(`CPS_STEP_LO_OFS) |=> reg_rdata[4:0] == cnt_d[4:0])
      else $error("Lower count half wrong.");
   chk_count_upper:
   assert property (rd_at(`CPS_STEP_HI_OFS) |=> reg_rdata[4:0] == cnt_d[9:5]
      && reg_rdata[31:7] == 25'h0) else $error("Upper count half wrong.");
   chk_diag_summary:
   assert property (rd_at(`CPS_DIAG_OFS) ##1 (|reg_rdata[15:0]) |-> reg_rdata[16])
      else $error("Summary fault bit missing.");
endmodule // cps_ctrl_sva

bind cps_ctrl cps_ctrl_sva #(.HOLD_CYC(HOLD_CYC)) chk (.clk, .rst_b, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .mcu_rst_b, .short_to_battery, .short_to_ground, .open_load,
   .thermal_warning_two, .b1_hs_a, .b1_ls_a, .b1_hs_b, .b1_ls_b, .b2_hs_c, .b2_hs_d, .b2_ls_c,
   .b2_ls_d, .any_output_fault_flag);

// ### bench/cps_host.sv
// Host controller model driving the register port and the controller reset pin.

// ============================================================
// Host model
module cps_host (
   // Clock
   input  wire         clk,
   // Register port
   output logic [7:0]  reg_addr,
   output logic [31:0] reg_wdata,
   output logic        reg_wr,
   output logic        reg_rd,
   input  wire  [31:0] reg_rdata,
   // Controller reset pin
   output logic        mcu_rst_b
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus and a running controller at time zero.
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 32'h0;
      reg_wr    = 1'h0;
      reg_rd    = 1'h0;
      mcu_rst_b = 1'h1;
   end

   // One write frame; direction, enable and step changes may share one call.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'h1;
      @(posedge clk);
      reg_wr    <= 1'h0;
   endtask

   // One read frame; data stands only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge clk);
      reg_rd   <= 1'h0;
      #1;
      d = reg_rdata;
   endtask

   // Moves the controller reset pin.
   task automatic mcu(input logic v);
      @(posedge clk);
      mcu_rst_b <= v;
   endtask
endmodule // cps_host

// ### bench/tb_top.sv
// Self-checking testbench of the power stage control block.
`include "cps_regs.vh"

// ============================================================
// Testbench
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'h0;
   logic        rst_b = 1'h0;
   logic [7:0]  short_to_battery = 8'h00, short_to_ground = 8'h00, open_load = 8'h00;
   logic        thermal_warning_two = 1'h0;
   wire  [7:0]  reg_addr;
   wire  [31:0] reg_wdata, reg_rdata;
   wire         reg_wr, reg_rd, mcu_rst_b, any_output_fault_flag;
   wire         b1_hs_a, b1_ls_a, b1_hs_b, b1_ls_b, b2_hs_c, b2_hs_d, b2_ls_c, b2_ls_d;
   wire  [7:0]  drv = {b2_ls_d, b2_ls_c, b2_hs_d, b2_hs_c, b1_ls_b, b1_hs_b, b1_ls_a, b1_hs_a};
   logic [7:0]  pos_tab [4] = '{8'h69, 8'h99, 8'h96, 8'h66};
   logic [1:0]  pos = 2'h0;
   logic [9:0]  cnt = `CPS_STEP_INIT, c;
   logic [31:0] d;
   int          n_errors = 0, samples_checked = 0;

   always #2 clk = ~clk;

   cps_host host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mcu_rst_b);
   cps_ctrl #(.HOLD_CYC(50)) uut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .mcu_rst_b, .short_to_battery, .short_to_ground, .open_load,
      .thermal_warning_two, .b1_hs_a, .b1_ls_a, .b1_hs_b, .b1_ls_b, .b2_hs_c, .b2_hs_d,
      .b2_ls_c, .b2_ls_d, .any_output_fault_flag);

   // ============================================================
   // Helpers
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic flt(input logic [7:0] sb, sg, ol, input logic th);
      @(posedge clk);
      short_to_battery    <= sb;
      short_to_ground     <= sg;
      open_load           <= ol;
      thermal_warning_two <= th;
   endtask
   // Reads both counter halves; their check bits must agree.
   task automatic rdc(output logic [9:0] v);
      logic [31:0] h, l;
      host.rd(`CPS_STEP_HI_OFS, h);
      host.rd(`CPS_STEP_LO_OFS, l);
      chk("count tags", h[6:5], l[6:5]);
      v = {h[4:0], l[4:0]};
   endtask
   // One motor step: step bit low in one frame, high in the next.
   task automatic stp(input logic dr, input bit look);
      host.wr(`CPS_CTRL_OFS, {29'h0, 1'h0, dr, 1'h1});
      if (look) wt(2);
      if (look) chk("held drives", pos_tab[pos], drv);
      host.wr(`CPS_CTRL_OFS, {29'h0, 1'h1, dr, 1'h1});
      pos = dr ? pos + 2'h1 : pos - 2'h1;
      if (dr && cnt != `CPS_STEP_MAX) cnt++;
      else if (!dr && cnt != `CPS_STEP_MIN) cnt--;
      if (look) wt(2);
      if (look) chk("stepped drives", pos_tab[pos], drv);
   endtask
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ============================================================
   // Tests
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'h1;
      host.rd(`CPS_CFG7_OFS, d);
      chk("arrangement reset", 32'h0, d);
      host.rd(8'hFC, d);
      chk("unmapped read", 32'h0, d);
      rdc(c);
      chk("count reset", 10'h200, c);
      chk("drives reset", 8'h00, drv);
      host.wr(`CPS_CTRL_OFS, 32'h7);
      wt(2);
      chk("enable only", 8'h69, drv);
      rdc(c);
      chk("count no step", cnt, c);
      repeat (5) stp(1'h1, 1'h1);
      repeat (2) stp(1'h0, 1'h1);
      rdc(c);
      chk("count stepped", cnt, c);
      host.wr(`CPS_CTRL_OFS, 32'h3);
      host.wr(`CPS_CTRL_OFS, 32'h5);
      pos++;
      cnt++;
      wt(2);
      chk("old direction", pos_tab[pos], drv);
      host.wr(`CPS_CTRL_OFS, 32'h9);
      cnt = `CPS_STEP_INIT;
      rdc(c);
      chk("soft reset", 10'h200, c);
      repeat (512) stp(1'h1, 1'h0);
      rdc(c);
      chk("count top", 10'h3FF, c);
      stp(1'h0, 1'h1);
      rdc(c);
      chk("count off top", 10'h3FE, c);
      repeat (1023) stp(1'h0, 1'h0);
      rdc(c);
      chk("count bottom", 10'h000, c);
      host.wr(`CPS_CTRL_OFS, 32'h6);
      wt(2);
      chk("disabled", 8'h00, drv);
      host.rd(`CPS_CTRL_OFS, d);
      chk("control word", 32'h6, d);
      host.wr(`CPS_CFG7_OFS, 32'h31);
      host.wr(`CPS_CMD_OFS, 32'h02);
      wt(2);
      chk("parallel low sides", 8'h0A, drv);
      host.wr(`CPS_CMD_OFS, 32'h03);
      wt(2);
      chk("no coherency check", 8'h0B, drv);
      host.rd(`CPS_CFG7_OFS, d);
      chk("config seven", 32'h31, d);
      host.wr(`CPS_CFG10_OFS, 32'h3);
      host.rd(`CPS_CFG10_OFS, d);
      chk("config ten", 32'h3, d);
      host.wr(`CPS_CFG7_OFS, 32'h04);
      host.wr(`CPS_CTRL_OFS, 32'h1);
      host.wr(`CPS_CMD_OFS, 32'h11);
      wt(2);
      chk("hold forces stages", 8'h35, drv);
      host.mcu(1'h0);
      wt(40);
      chk("hold running", 1'h1, drv[0]);
      wt(30);
      chk("hold expired", 1'h0, drv[0]);
      chk("hold off on c", 1'h1, drv[4]);
      host.mcu(1'h1);
      host.wr(`CPS_CFG7_OFS, 32'h08);
      host.mcu(1'h0);
      wt(20);
      host.wr(`CPS_CMD_OFS, 32'h11);
      wt(70);
      chk("host took over", 1'h1, drv[4]);
      host.mcu(1'h1);
      host.wr(`CPS_CMD_OFS, 32'h0);
      flt(8'h00, 8'h01, 8'h00, 1'h0);
      wt(6);
      host.wr(`CPS_CMD_OFS, 32'h1);
      flt(8'h01, 8'h00, 8'h00, 1'h0);
      wt(2600);
      flt(8'h00, 8'h00, 8'h00, 1'h0);
      wt(4);
      chk("tripped off", 1'h0, drv[0]);
      chk("summary pin", 1'h1, any_output_fault_flag);
      host.rd(`CPS_STAT_OFS, d);
      chk("status word", 32'h804, d);
      host.rd(`CPS_DIAG_OFS, d);
      chk("on fault wins", 32'h10001, d);
      host.rd(`CPS_DIAG_OFS, d);
      chk("cleared by read", 32'h0, d);
      flt(8'h00, 8'h08, 8'h00, 1'h0);
      wt(5);
      flt(8'h00, 8'h00, 8'h08, 1'h0);
      wt(5);
      flt(8'h00, 8'h00, 8'h00, 1'h1);
      wt(5);
      flt(8'h00, 8'h00, 8'h00, 1'h0);
      wt(4);
      host.rd(`CPS_DIAG_OFS, d);
      chk("first off fault", 32'h10080, d & 32'h1FFFF);
      chk("thermal warning", 1'h1, d[17]);
      wrap_up();
   end

   // Cuts a hang short.
   initial begin
      #80000;
      n_errors++;
      $display("Error watchdog expected finish seen timeout");
      wrap_up();
   end
endmodule // tb_top
